// [common/nad_map.vh]
// register map, field positions, reset values and address layout of the node decoder
`ifndef NAD_MAP_VH
`define NAD_MAP_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define NAD_BANK_SEL_ADDR 32'h3FF00400
`define NAD_PORT_CFG_ADDR 32'h3FF00404
`define NAD_STATUS_ADDR 32'h3FF00408

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define NAD_BANK_SEL_RST 4'h0
`define NAD_PORT_CFG_RST 5'h00

// ----------------------------------------------------------------
// port configuration fields
// ----------------------------------------------------------------
`define NAD_CFG_ATTACH_LSB 0
`define NAD_CFG_ATTACH_MSB 3
`define NAD_CFG_FOUR_CHIP 4

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define NAD_ST_MULTI 0
`define NAD_ST_NODE_LSB 1
`define NAD_ST_NODE_MSB 2
`define NAD_ST_LOCAL_LSB 3
`define NAD_ST_LOCAL_MSB 6

// ----------------------------------------------------------------
// address layout
// ----------------------------------------------------------------
`define NAD_ADDR_W 48
`define NAD_NODE_MSB 47
`define NAD_NODE_LSB 44
`define NAD_HALF_BIT 43
`define NAD_PORT_MSB 42
`define NAD_PORT_LSB 41
`define NAD_BANK_LSB_DEF 6'h05
`define NAD_BANK_CODE_RSV 4'hF

// ----------------------------------------------------------------
// strap synchroniser fill count
// ----------------------------------------------------------------
`define NAD_SYNC_FILL 2'h3

// ----------------------------------------------------------------
// directional port numbers
// ----------------------------------------------------------------
`define NAD_PORT_EAST 2'h0
`define NAD_PORT_SOUTH 2'h1
`define NAD_PORT_WEST 2'h2
`define NAD_PORT_NORTH 2'h3

`endif

// [rtl/nad_decoder.v]
// node address decoder: routes request addresses to cache banks or directional ports
//
// Chosen here: the APB interface to the registers.
`include "nad_map.vh"
`default_nettype none

module nad_decoder
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire coherent_multichip_strap,
  input wire [1:0] node_number_strap,
  input wire req_valid,
  input wire [47:0] req_addr,
  input wire req_from_pci,
  output reg route_valid,
  output reg [47:0] route_addr,
  output reg route_to_l2,
  output reg [1:0] route_l2_bank,
  output reg route_to_port,
  output reg [1:0] route_port,
  output reg route_remote,
  output reg route_refused,
  output reg route_coherent
);

  // ----------------------------------------------------------------
  // strap synchronisers and capture
  // ----------------------------------------------------------------
  reg [2:0] multi_sync_reg;
  reg [1:0] node_s1_reg;
  reg [1:0] node_s2_reg;
  reg [1:0] node_s3_reg;
  reg [1:0] fill_cnt_reg;
  reg strap_done_reg;
  reg multi_mode_reg;
  reg [1:0] node_num_reg;

  // three flip-flop chains for the strap pins
  // the fill count tells when the last stage holds a pin value and no longer
  // the zero left by reset, so a high strap is never mistaken for a low one
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fill_cnt_reg <= 2'h0;
      multi_sync_reg <= 3'h0;
      node_s1_reg <= 2'h0;
      node_s2_reg <= 2'h0;
      node_s3_reg <= 2'h0;
    end
    else
    begin
      multi_sync_reg <= {multi_sync_reg[1:0], coherent_multichip_strap};
      node_s1_reg <= node_number_strap;
      node_s2_reg <= node_s1_reg;
      node_s3_reg <= node_s2_reg;
      if (fill_cnt_reg != `NAD_SYNC_FILL)
        fill_cnt_reg <= fill_cnt_reg + 2'h1;
    end
  end

  // straps are caught once, when both late stages agree after the chain filled;
  // only the second and third stages are read, the first may still be settling;
  // later pin changes are ignored until the next reset
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_done_reg <= 1'b0;
      multi_mode_reg <= 1'b0;
      node_num_reg <= 2'h0;
    end
    else if (!strap_done_reg && (fill_cnt_reg == `NAD_SYNC_FILL)
             && (multi_sync_reg[2] == multi_sync_reg[1]) && (node_s3_reg == node_s2_reg))
    begin
      strap_done_reg <= 1'b1;
      multi_mode_reg <= multi_sync_reg[2];
      node_num_reg <= node_s3_reg;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [3:0] bank_sel_reg;
  reg [4:0] port_cfg_reg;
  reg [3:0] local_node_next;
  wire [31:0] status_word;
  wire apb_setup;
  wire apb_write;
  reg [31:0] rdata_next;
  reg addr_hit_next;

  // setup phase and a completing write
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pready && pwrite && !pslverr;

  // local node number: zero in single chip, strap value in multichip
  // the strap gives two bits; the upper two bits of the node field stay zero
  always @*
  begin
    if (multi_mode_reg)
      local_node_next = {2'h0, node_num_reg};
    else
      local_node_next = 4'h0;
  end

  assign status_word = {25'h0, local_node_next, node_num_reg, multi_mode_reg};

  // read mux and address decode
  // unused upper bits read as zero
  always @*
  begin
    rdata_next = 32'h00000000;
    addr_hit_next = 1'b1;
    case (paddr)
      `NAD_BANK_SEL_ADDR: rdata_next = {28'h0000000, bank_sel_reg};
      `NAD_PORT_CFG_ADDR: rdata_next = {27'h0, port_cfg_reg};
      `NAD_STATUS_ADDR: rdata_next = status_word;
      default: addr_hit_next = 1'b0;
    endcase
  end

  // apb answer: ready in the first access cycle, no wait states
  // pready is raised by the setup edge itself, so it stands exactly in the access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= apb_setup;
      pslverr <= apb_setup && !addr_hit_next;
      if (apb_setup && !pwrite)
        prdata <= rdata_next;
    end
  end

  // writable registers, updated at the completing access edge
  // an unmapped address raises pslverr and leaves both registers untouched
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bank_sel_reg <= `NAD_BANK_SEL_RST;
      port_cfg_reg <= `NAD_PORT_CFG_RST;
    end
    else if (apb_write)
    begin
      if (paddr == `NAD_BANK_SEL_ADDR)
        bank_sel_reg <= pwdata[3:0];
      if (paddr == `NAD_PORT_CFG_ADDR)
        port_cfg_reg <= pwdata[4:0];
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  reg [5:0] bank_lsb_next;
  reg [1:0] bank_next;
  reg [3:0] node_field_next;
  reg node_ok_next;
  reg is_local_next;
  reg to_l2_next;
  reg to_port_next;
  reg [1:0] port_next;
  reg remote_next;
  reg refused_next;
  reg [47:0] shifted_addr;

  // low bit of the interleave pair
  // codes 0 and 15 both give the reset pair; 15 is held back as reserved
  always @*
  begin
    if (bank_sel_reg == `NAD_BANK_CODE_RSV)
      bank_lsb_next = `NAD_BANK_LSB_DEF;
    else if (bank_sel_reg == 4'h0)
      bank_lsb_next = `NAD_BANK_LSB_DEF;
    else
      bank_lsb_next = {1'b0, bank_sel_reg, 1'b0} + 6'h06;
  end

  // bank pick from the selected pair
  // the shift is by at most 34, so the pair never runs past bit 47
  always @*
  begin
    shifted_addr = req_addr >> bank_lsb_next;
    bank_next = shifted_addr[1:0];
  end

  // node field, locality and target choice
  // a bad node is refused first; a remote node leaves by the port named by its low
  // bits, and a local one splits on bit 43 between cache banks and directional ports
  always @*
  begin
    node_field_next = req_addr[`NAD_NODE_MSB:`NAD_NODE_LSB];
    is_local_next = (node_field_next == local_node_next);
    if (!multi_mode_reg)
      node_ok_next = is_local_next;
    else if (port_cfg_reg[`NAD_CFG_FOUR_CHIP])
      node_ok_next = (node_field_next[3:2] == 2'h0);
    else
      node_ok_next = (node_field_next[3:1] == 3'h0);
    to_l2_next = 1'b0;
    to_port_next = 1'b0;
    port_next = `NAD_PORT_EAST;
    remote_next = 1'b0;
    refused_next = 1'b0;
    if (!node_ok_next)
      refused_next = 1'b1;
    else if (!is_local_next)
    begin
      remote_next = 1'b1;
      to_port_next = 1'b1;
      port_next = node_field_next[1:0];
      refused_next = !port_cfg_reg[node_field_next[1:0]];
    end
    else if (!req_addr[`NAD_HALF_BIT])
      to_l2_next = 1'b1;
    else
    begin
      port_next = req_addr[`NAD_PORT_MSB:`NAD_PORT_LSB];
      if (port_cfg_reg[req_addr[`NAD_PORT_MSB:`NAD_PORT_LSB]])
        to_port_next = 1'b1;
      else
        refused_next = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // route outputs, one cycle after the request
  // ----------------------------------------------------------------
  // strobes drop back to zero between requests; address, bank, port and remote
  // keep their last value so a consumer may look at them late
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      route_valid <= 1'b0;
      route_addr <= 48'h000000000000;
      route_to_l2 <= 1'b0;
      route_l2_bank <= 2'h0;
      route_to_port <= 1'b0;
      route_port <= 2'h0;
      route_remote <= 1'b0;
      route_refused <= 1'b0;
      route_coherent <= 1'b0;
    end
    else
    begin
      route_valid <= req_valid;
      if (req_valid)
      begin
        route_addr <= req_addr;
        route_to_l2 <= to_l2_next;
        route_l2_bank <= to_l2_next ? bank_next : 2'h0;
        route_to_port <= to_port_next;
        route_port <= port_next;
        route_remote <= remote_next;
        route_refused <= refused_next;
        route_coherent <= !req_from_pci && !refused_next;
      end
      else
      begin
        route_to_l2 <= 1'b0;
        route_to_port <= 1'b0;
        route_refused <= 1'b0;
        route_coherent <= 1'b0;
      end
    end
  end

endmodule // nad_decoder

`default_nettype wire

// [dv/nad_chk.sv]
// assertion checker on the node decoder ports
`default_nettype none
module nad_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire req_valid,
  input wire [47:0] req_addr,
  input wire req_from_pci,
  input wire route_valid,
  input wire [47:0] route_addr,
  input wire route_to_l2,
  input wire route_to_port,
  input wire [1:0] route_port,
  input wire route_remote,
  input wire route_refused,
  input wire route_coherent
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb setup step
  sequence s_setup; psel && !penable; endsequence
  chk_apb_answer: assert property (s_setup |=> pready) else $error("late pready");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("long pready");
  chk_route_latency: assert property (req_valid |=> route_valid) else $error("no route");
  chk_route_idle: assert property (
    !req_valid |=> !route_valid && !route_coherent) else $error("stray route");
  chk_addr_copy: assert property (
    req_valid |=> route_addr == $past(req_addr)) else $error("bad addr");
  chk_cache_half: assert property (
    route_valid && route_to_l2 |-> !route_addr[43] && !route_to_port) else $error("bad l2");
  chk_port_dir: assert property (
    route_valid && route_to_port && !route_remote |-> route_addr[43]
    && route_port == route_addr[42:41]) else $error("bad port");
  chk_pci_coherent: assert property (
    route_valid |-> route_coherent == (!$past(req_from_pci) && !route_refused))
    else $error("bad coherence");
endmodule // nad_chk
bind nad_decoder nad_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .req_valid,
  .req_addr, .req_from_pci, .route_valid, .route_addr, .route_to_l2, .route_to_port,
  .route_port, .route_remote, .route_refused, .route_coherent);
`default_nettype wire

// [dv/nad_core_model.sv]
// requesting core model issuing one-cycle decode requests
`default_nettype none
module nad_core_model (
  input wire logic clk,
  output logic req_valid,
  output logic [47:0] req_addr,
  output logic req_from_pci
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle lines at time zero
  initial
  begin
    req_valid = 1'h0;
    req_addr = 48'h0;
    req_from_pci = 1'h0;
  end
  // strobe for one edge after a gap, then lines scrambled so stale values never match
  task automatic send(input logic [47:0] a, input logic p, input int gap);
    repeat (gap + 1) @(posedge clk);
    req_valid <= 1'h1;
    req_addr <= a;
    req_from_pci <= p;
    @(posedge clk);
    req_valid <= 1'h0;
    req_addr <= ~a;
    req_from_pci <= ~p;
    #1;
  endtask
endmodule // nad_core_model
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the node address decoder
`include "nad_map.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, rd;
  logic coherent_multichip_strap = 1'h0;
  logic [1:0] node_number_strap = 2'h0;
  logic [47:0] a;
  wire [31:0] prdata;
  wire pready, pslverr, req_valid, req_from_pci, route_valid, route_to_l2, route_to_port;
  wire route_remote, route_refused, route_coherent;
  wire [1:0] route_l2_bank, route_port;
  wire [47:0] req_addr, route_addr;
  int num_errors = 0, check_count = 0;
  // clock, requester and decoder
  always #2.5 pclk = ~pclk;
  nad_core_model core (.clk(pclk), .req_valid, .req_addr, .req_from_pci);
  nad_decoder DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .coherent_multichip_strap, .node_number_strap, .req_valid, .req_addr,
    .req_from_pci, .route_valid, .route_addr, .route_to_l2, .route_l2_bank, .route_to_port,
    .route_port, .route_remote, .route_refused, .route_coherent);
  task automatic chk(input string n, input logic [47:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one apb transfer, held until pready is sampled
  task automatic apb(input logic w, input logic [31:0] ad, wd);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1)
    begin
      num_errors++;
      close_out;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // expected bank from the select code
  function automatic logic [1:0] bank(input logic [3:0] c, input logic [47:0] x);
    return (c == 4'h0 || c == 4'hF) ? x[6:5] : x[2 * c + 6 +: 2];
  endfunction
  task automatic req(input logic [47:0] x, input logic p, l2, rf, input logic [1:0] bk, pt);
    core.send(x, p, $urandom_range(2));
    chk("valid", route_valid, 48'h1);
    chk("addr", route_addr, x);
    chk("l2", route_to_l2, l2);
    chk("refused", route_refused, rf);
    chk("coherent", route_coherent, !p && !rf);
    if (l2)
      chk("bank", route_l2_bank, bk);
    else if (!rf)
      chk("port", {route_to_port, route_port}, {1'h1, pt});
  endtask
  // main sequence
  initial
  begin
    void'($urandom(94473));
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    repeat (6) @(posedge pclk);
    apb(1'h0, `NAD_BANK_SEL_ADDR, 32'h0);
    chk("bank_sel", rd, 48'h0);
    apb(1'h1, 32'h3FF0040C, 32'h5);
    chk("unmapped", err, 48'h1);
    $display("registers done");
    for (int c = 0; c < 16; c++)
    begin
      apb(1'h1, `NAD_BANK_SEL_ADDR, c);
      apb(1'h0, `NAD_BANK_SEL_ADDR, 32'h0);
      chk("code", rd, c);
      repeat (3)
      begin
        a = 48'({$urandom, $urandom});
        a[47:43] = 5'h00;
        req(a, 1'($urandom_range(1)), 1'h1, 1'h0, bank(c[3:0], a), 2'h0);
      end
    end
    $display("banks done");
    // east and west attached only; foreign nodes refused in single chip mode
    apb(1'h1, `NAD_PORT_CFG_ADDR, 32'h5);
    for (int d = 4; d < 8; d++)
    begin
      a = 48'({$urandom, $urandom});
      a[47:41] = 7'(d);
      req(a, 1'($urandom_range(1)), 1'h0, d[0], 2'h0, d[1:0]);
      a[47:44] = 4'($urandom_range(15, 1));
      req(a, 1'($urandom_range(1)), 1'h0, 1'h1, 2'h0, 2'h0);
    end
    $display("ports done");
    @(posedge pclk);
    presetn <= 1'h0;
    coherent_multichip_strap <= 1'h1;
    node_number_strap <= 2'h2;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    repeat (6) @(posedge pclk);
    apb(1'h0, `NAD_STATUS_ADDR, 32'h0);
    chk("status", rd, 48'h15);
    apb(1'h1, `NAD_PORT_CFG_ADDR, 32'h1F);
    a = {4'h2, 44'h0};
    req(a, 1'h0, 1'h1, 1'h0, 2'h0, 2'h0);
    chk("local", route_remote, 48'h0);
    a[47:44] = 4'h3;
    req(a, 1'h0, 1'h0, 1'h0, 2'h0, 2'h3);
    chk("remote", route_remote, 48'h1);
    // north port detached, then four-chip mode off: the remote node 3 is refused both times
    apb(1'h1, `NAD_PORT_CFG_ADDR, 32'h17);
    req(a, 1'h0, 1'h0, 1'h1, 2'h0, 2'h0);
    apb(1'h1, `NAD_PORT_CFG_ADDR, 32'h0F);
    req(a, 1'h0, 1'h0, 1'h1, 2'h0, 2'h0);
    // a strap change after capture is ignored until the next reset
    @(posedge pclk);
    node_number_strap <= 2'h1;
    repeat (6) @(posedge pclk);
    apb(1'h0, `NAD_STATUS_ADDR, 32'h0);
    chk("status_held", rd, 48'h15);
    $display("multichip done");
    close_out;
  end
  // cut a hung run short
  initial
  begin
    #200us;
    num_errors++;
    close_out;
  end
endmodule // testbench
`default_nettype wire
